// ===== rtl/lcs_register_bank.sv
/*
 * Configuration, program-counter and status registers of a three-channel
 * LED controller, reached as a serial-bus target on scl and sda.
 * Assumes bus pins are synchronous to sys_clk and slow against it; the
 * engines, operating-mode register and pump sit outside and drive inputs.
 */
//
// Functional notes
// [RL1] Blue current is a linear 8-bit code, 0.1 mA per step, 0 to 25.5 mA.
// [RL2] Blue current resets to AFh, that is 17.5 mA.
// [RL3] PWM fast select gives 256 Hz when clear, 558 Hz when set.
// [RL4] Host always writes zero to configuration bit 7.
// [RL5] Power-save enable turns automatic power save on when set.
// [RL6] Pump mode: 00 off, 01 forced 1x, 10 forced 1.5x, 11 automatic.
// [RL7] Red supply select: 0 from pump output, 1 from battery.
// [RL8] Clock select: 00 external, 01/11 internal, 10 automatic with detection.
// [RL9] Each channel has a 4-bit counter in the low nibble, reset zero.
// [RL10] Counter access only while that channel's execution field is 11b.
// [RL11] In standby a counter accepts writes but returns no read value.
// [RL12] A counter written in standby takes effect only after startup.
// [RL13] Counter reads are serviced only in normal state.
// [RL14] Changing a channel's operating mode resets its counter to zero.
// [RL15] Pump status reports actual state: off, 1x, 1.5x, power save.
// [RL16] Status bit shows clock in use: 0 internal, 1 external 32 kHz.
// [RL17] Per-channel end flags: red bit 2, green bit 1, blue bit 0.
// [RL18] Status read clears all flags and releases the interrupt pin.
// [RL19] Execution code 00b is hold: finish instruction, then stop.
// [RL20] Operating mode 01b is load mode and resets the counter.
// [RL21] Unused counter and status bits read zero, writes ignored.
// [RL22] Host reads status after interrupt to learn ends and rearm pin.
`timescale 1ns/100ps
`default_nettype none
module lcs_register_bank
    import lcs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaDriveN_q,
    input wire logic [2:0][1:0] execControl,
    input wire logic [2:0][1:0] modeSel,
    input wire logic [2:0] pcAdvance,
    input wire logic [2:0] endPulse,
    input wire logic deviceNormal,
    input wire logic [1:0] pumpStateReport,
    input wire logic clockDetected,
    output logic [7:0] blueCurrent_q,
    output lcs_config_type config_q,
    output logic externalClockInUse_q,
    output logic pwmStepTick_q,
    output logic [2:0][3:0] programCounter,
    output logic intDriveN_q
);
    lcs_bus_state_type state_q;
    logic sclPrev_q;
    logic sdaPrev_q;
    logic [3:0] bitCnt_q;
    logic [7:0] shift_q;
    logic [7:0] ptr_q;
    logic readMode_q;
    logic [2:0] intFlags_q;
    logic [8:0] pwmCnt_q;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic regWrite;
    logic loadRead;
    logic statusRead;
    logic [7:0] readByte;
    logic [2:0] pcWrite;
    logic [2:0] intFlags_d;
    logic [8:0] pwmDiv;

    assign sclRise = scl && !sclPrev_q;
    assign sclFall = !scl && sclPrev_q;
    assign startSeen = scl && sclPrev_q && sdaPrev_q && !sdaIn;
    assign stopSeen = scl && sclPrev_q && !sdaPrev_q && sdaIn;
    assign regWrite = state_q == BUS_WDATA && sclFall && bitCnt_q == 4'h8;
    assign loadRead = sclFall && ((state_q == BUS_ADDR_ACK && readMode_q)
                                  || state_q == BUS_RDATA_ACK);
    assign statusRead = loadRead && ptr_q == OFF_STATUS;

    // Counter reads need execution field 11b and a running device, else zero
    function automatic logic [7:0] pcRead(input logic [3:0] pc, input logic [1:0] exec);
        if (deviceNormal && exec == EXEC_PC_ACCESS) // RL13 RL11
            pcRead = {4'h0, pc}; // RL21
        else
            pcRead = 8'h00;
    endfunction : pcRead

    always_comb
    begin
        if (ptr_q == OFF_BLUE_CURRENT)
            readByte = blueCurrent_q;
        else if (ptr_q == OFF_CONFIG)
            readByte = config_q;
        else if (ptr_q == OFF_RED_PC)
            readByte = pcRead(programCounter[CH_RED], execControl[CH_RED]);
        else if (ptr_q == OFF_GREEN_PC)
            readByte = pcRead(programCounter[CH_GREEN], execControl[CH_GREEN]);
        else if (ptr_q == OFF_BLUE_PC)
            readByte = pcRead(programCounter[CH_BLUE], execControl[CH_BLUE]);
        else if (ptr_q == OFF_STATUS)
        begin
            readByte = 8'h00; // RL21
            readByte[ST_PUMP_LSB +: 2] = pumpStateReport; // RL15
            readByte[ST_EXT_CLK_BIT] = externalClockInUse_q; // RL16
            readByte[ST_FLAGS_LSB +: 3] = intFlags_q; // RL17
        end
        else
            readByte = 8'h00;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end
        else
        begin
            sclPrev_q <= scl;
            sdaPrev_q <= sdaIn;
        end
    end

    // Serial-bus target; sda only changes while scl is low
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            state_q <= BUS_IDLE;
            bitCnt_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            readMode_q <= 1'b0;
            sdaDriveN_q <= 1'b1;
        end
        else if (startSeen)
        begin
            state_q <= BUS_ADDR;
            bitCnt_q <= 4'h0;
            sdaDriveN_q <= 1'b1;
        end
        else if (stopSeen)
        begin
            state_q <= BUS_IDLE;
            sdaDriveN_q <= 1'b1;
        end
        else if (loadRead)
        begin
            state_q <= BUS_RDATA;
            shift_q <= readByte;
            sdaDriveN_q <= readByte[7];
            bitCnt_q <= 4'h0;
            ptr_q <= ptr_q + 8'h01;
        end
        else
        begin
            case (state_q)
                BUS_ADDR, BUS_REG, BUS_WDATA:
                begin
                    if (sclRise)
                    begin
                        shift_q <= {shift_q[6:0], sdaIn};
                        bitCnt_q <= bitCnt_q + 4'h1;
                    end
                    else if (sclFall && bitCnt_q == 4'h8)
                    begin
                        bitCnt_q <= 4'h0;
                        sdaDriveN_q <= 1'b0;
                        if (state_q == BUS_ADDR)
                        begin
                            if (shift_q[7:1] == DEV_ADDR)
                            begin
                                state_q <= BUS_ADDR_ACK;
                                readMode_q <= shift_q[0];
                            end
                            else
                            begin
                                state_q <= BUS_IDLE;
                                sdaDriveN_q <= 1'b1;
                            end
                        end
                        else if (state_q == BUS_REG)
                        begin
                            state_q <= BUS_REG_ACK;
                            ptr_q <= shift_q;
                        end
                        else
                            state_q <= BUS_WDATA_ACK;
                    end
                end
                BUS_ADDR_ACK, BUS_REG_ACK:
                begin
                    if (sclFall)
                    begin
                        sdaDriveN_q <= 1'b1;
                        state_q <= (state_q == BUS_ADDR_ACK) ? BUS_REG : BUS_WDATA;
                    end
                end
                BUS_WDATA_ACK:
                begin
                    if (sclFall)
                    begin
                        sdaDriveN_q <= 1'b1;
                        state_q <= BUS_WDATA;
                        ptr_q <= ptr_q + 8'h01;
                    end
                end
                BUS_RDATA:
                begin
                    if (sclFall)
                    begin
                        bitCnt_q <= bitCnt_q + 4'h1;
                        if (bitCnt_q == 4'h7)
                        begin
                            sdaDriveN_q <= 1'b1;
                            state_q <= BUS_RDATA_ACK;
                        end
                        else
                        begin
                            shift_q <= {shift_q[6:0], 1'b0};
                            sdaDriveN_q <= shift_q[6];
                        end
                    end
                end
                BUS_RDATA_ACK:
                begin
                    if (sclRise && sdaIn)
                        state_q <= BUS_IDLE;
                end
                default:
                    state_q <= BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            blueCurrent_q <= RST_BLUE_CURRENT; // RL2
        else if (regWrite && ptr_q == OFF_BLUE_CURRENT)
            blueCurrent_q <= shift_q; // RL1
    end

    // Top bit held at zero so a stray host write cannot reach it
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            config_q <= RST_CONFIG;
        else if (regWrite && ptr_q == OFF_CONFIG)
            config_q <= {1'b0, shift_q[6:0]}; // RL4 RL3 RL5 RL6 RL7 RL8
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            externalClockInUse_q <= 1'b0;
        else if ({config_q.clockDetectEnable, config_q.internalClockEnable} == CLKSEL_EXTERNAL)
            externalClockInUse_q <= 1'b1; // RL8 RL16
        else if ({config_q.clockDetectEnable, config_q.internalClockEnable} == CLKSEL_AUTO)
            externalClockInUse_q <= clockDetected;
        else
            externalClockInUse_q <= 1'b0;
    end

    // PWM step enable, 256 steps per period
    assign pwmDiv = config_q.pwmFastSelect ? PWM_DIV_FAST : PWM_DIV_SLOW; // RL3

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || pwmCnt_q >= pwmDiv - 9'h001)
            pwmCnt_q <= 9'h000;
        else
            pwmCnt_q <= pwmCnt_q + 9'h001;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            pwmStepTick_q <= 1'b0;
        else
            pwmStepTick_q <= pwmCnt_q >= pwmDiv - 9'h001;
    end

    // A new end in the clearing cycle survives the clear
    assign intFlags_d = (statusRead ? RST_FLAGS : intFlags_q) | endPulse; // RL17 RL18

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            intFlags_q <= RST_FLAGS;
            intDriveN_q <= 1'b1;
        end
        else
        begin
            intFlags_q <= intFlags_d;
            intDriveN_q <= !(|intFlags_d); // RL18
        end
    end

    assign pcWrite[CH_RED] = regWrite && ptr_q == OFF_RED_PC;
    assign pcWrite[CH_GREEN] = regWrite && ptr_q == OFF_GREEN_PC;
    assign pcWrite[CH_BLUE] = regWrite && ptr_q == OFF_BLUE_PC;

    for (genvar ch = 0; ch < 3; ch++)
    begin : g_pc
        lcs_program_counter u_pc (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .hostWrite(pcWrite[ch]),
            .hostData(shift_q[3:0]), // RL21
            .execControl(execControl[ch]),
            .modeSel(modeSel[ch]),
            .deviceNormal(deviceNormal),
            .advance(pcAdvance[ch]),
            .pcValue_q(programCounter[ch])
        );
    end

    property p_currentReset;
        @(posedge sys_clk) sys_rst |=> blueCurrent_q == RST_BLUE_CURRENT;
    endproperty
    a_currentReset: assert property (p_currentReset) else $error("blue current reset"); // RL2

    property p_cfgTopZero;
        @(posedge sys_clk) disable iff (sys_rst)
        (regWrite && ptr_q == OFF_CONFIG) |=> config_q.reserved == 1'b0
            && config_q[6:0] == $past(shift_q[6:0]);
    endproperty
    a_cfgTopZero: assert property (p_cfgTopZero) else $error("config write wrong"); // RL4

    property p_readClears;
        @(posedge sys_clk) disable iff (sys_rst)
        (statusRead && endPulse == 3'h0) |=> intFlags_q == RST_FLAGS && intDriveN_q;
    endproperty
    a_readClears: assert property (p_readClears) else $error("status read kept flags"); // RL18

    property p_setWins;
        @(posedge sys_clk) disable iff (sys_rst)
        (endPulse != 3'h0) |=> (intFlags_q & $past(endPulse)) == $past(endPulse)
            && !intDriveN_q;
    endproperty
    a_setWins: assert property (p_setWins) else $error("end flag lost"); // RL17

    property p_standbyReadZero;
        @(posedge sys_clk) disable iff (sys_rst)
        (loadRead && !deviceNormal && ptr_q >= OFF_RED_PC && ptr_q <= OFF_BLUE_PC)
        |=> shift_q == 8'h00;
    endproperty
    a_standbyReadZero: assert property (p_standbyReadZero) else $error("pc read in standby"); // RL13

    property p_extClock;
        @(posedge sys_clk) disable iff (sys_rst)
        ({config_q.clockDetectEnable, config_q.internalClockEnable} == CLKSEL_EXTERNAL)
        ##1 ({config_q.clockDetectEnable, config_q.internalClockEnable} == CLKSEL_EXTERNAL)
        |-> externalClockInUse_q;
    endproperty
    a_extClock: assert property (p_extClock) else $error("clock in use wrong"); // RL16

endmodule : lcs_register_bank
`default_nettype wire

// ===== rtl/lcs_pkg.sv
/*
 * Package for the LED configuration and status register bank: register
 * offsets, reset values, field positions, codes, timing counts and types.
 * Assumes a 25 MHz system clock and a serial-bus target in front of it.
 */
package lcs_pkg;

    // Timing
    localparam int CLK_HZ = 25_000_000;
    localparam int PWM_SLOW_HZ = 256;
    localparam int PWM_FAST_HZ = 558;
    localparam int PWM_STEPS = 256;
    localparam logic [8:0] PWM_DIV_SLOW = 9'(CLK_HZ / (PWM_SLOW_HZ * PWM_STEPS));
    localparam logic [8:0] PWM_DIV_FAST = 9'(CLK_HZ / (PWM_FAST_HZ * PWM_STEPS));

    // Current code: linear, 0.1 mA per step, in microamps
    localparam int CURRENT_STEP_UA = 100;
    localparam int CURRENT_MAX_UA = 25_500;

    // Serial-bus target address, value is arbitrary
    localparam logic [6:0] DEV_ADDR = 7'h2A;

    // Register offsets
    localparam logic [7:0] OFF_BLUE_CURRENT = 8'h07;
    localparam logic [7:0] OFF_CONFIG = 8'h08;
    localparam logic [7:0] OFF_RED_PC = 8'h09;
    localparam logic [7:0] OFF_GREEN_PC = 8'h0A;
    localparam logic [7:0] OFF_BLUE_PC = 8'h0B;
    localparam logic [7:0] OFF_STATUS = 8'h0C;

    // Reset values
    localparam logic [7:0] RST_BLUE_CURRENT = 8'hAF;
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [3:0] RST_PC = 4'h0;
    localparam logic [2:0] RST_FLAGS = 3'h0;

    // Channel index, also the interrupt flag bit position
    localparam int CH_BLUE = 0;
    localparam int CH_GREEN = 1;
    localparam int CH_RED = 2;

    // Status field positions
    localparam int ST_FLAGS_LSB = 0;
    localparam int ST_EXT_CLK_BIT = 3;
    localparam int ST_PUMP_LSB = 4;

    // Execution and mode codes
    localparam logic [1:0] EXEC_PC_ACCESS = 2'h3;
    localparam logic [1:0] EXEC_HOLD = 2'h0;
    localparam logic [1:0] MODE_LOAD = 2'h1;

    // Clock select codes {clockDetect, internalClock}
    localparam logic [1:0] CLKSEL_EXTERNAL = 2'h0;
    localparam logic [1:0] CLKSEL_AUTO = 2'h2;

    typedef enum logic [1:0] {
        PUMP_OFF = 2'b00,
        PUMP_1X = 2'b01,
        PUMP_1P5X = 2'b10,
        PUMP_AUTO = 2'b11
    } lcs_pump_type;

    typedef struct packed {
        logic reserved;
        logic pwmFastSelect;
        logic powerSaveEnable;
        lcs_pump_type pumpModeSelect;
        logic redSupplySelect;
        logic clockDetectEnable;
        logic internalClockEnable;
    } lcs_config_type;

    typedef enum logic [3:0] {
        BUS_IDLE = 4'b0000,
        BUS_ADDR = 4'b0001,
        BUS_ADDR_ACK = 4'b0010,
        BUS_REG = 4'b0011,
        BUS_REG_ACK = 4'b0100,
        BUS_WDATA = 4'b0101,
        BUS_WDATA_ACK = 4'b0110,
        BUS_RDATA = 4'b0111,
        BUS_RDATA_ACK = 4'b1000
    } lcs_bus_state_type;

endpackage : lcs_pkg

// ===== rtl/lcs_program_counter.sv
/*
 * One channel's 4-bit program counter with host access gating, deferred
 * standby writes and reset on operating-mode change.
 * Assumes the engine pulses advance once per instruction step.
 */
`timescale 1ns/100ps
`default_nettype none
module lcs_program_counter
    import lcs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic hostWrite,
    input wire logic [3:0] hostData,
    input wire logic [1:0] execControl,
    input wire logic [1:0] modeSel,
    input wire logic deviceNormal,
    input wire logic advance,
    output logic [3:0] pcValue_q
);
    logic [1:0] modePrev_q;
    logic [3:0] pending_q;
    logic pendingValid_q;
    logic modeChanged;
    logic writeOk;

    assign modeChanged = modeSel != modePrev_q;
    assign writeOk = hostWrite && execControl == EXEC_PC_ACCESS; // RL10

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            modePrev_q <= 2'h0;
        else
            modePrev_q <= modeSel;
    end

    // Standby writes park here until the device is running
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || modeChanged)
        begin
            pending_q <= RST_PC;
            pendingValid_q <= 1'b0;
        end
        else if (writeOk && !deviceNormal)
        begin
            pending_q <= hostData; // RL11
            pendingValid_q <= 1'b1;
        end
        else if (deviceNormal)
            pendingValid_q <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            pcValue_q <= RST_PC; // RL9
        else if (modeChanged || modeSel == MODE_LOAD)
            pcValue_q <= RST_PC; // RL14 RL20
        else if (writeOk && deviceNormal)
            pcValue_q <= hostData;
        else if (pendingValid_q && deviceNormal)
            pcValue_q <= pending_q; // RL12
        // Hold freezes the count until the field changes
        else if (advance && deviceNormal && execControl != EXEC_HOLD)
            pcValue_q <= pcValue_q + 4'h1; // RL19
    end

    property p_modeReset;
        @(posedge sys_clk) disable iff (sys_rst)
        (modeSel != modePrev_q) |=> pcValue_q == RST_PC;
    endproperty
    a_modeReset: assert property (p_modeReset) else $error("pc kept after mode change"); // RL14

    property p_standbyHold;
        @(posedge sys_clk) disable iff (sys_rst)
        (writeOk && !deviceNormal && !modeChanged && modeSel != MODE_LOAD)
        |=> pcValue_q == $past(pcValue_q);
    endproperty
    a_standbyHold: assert property (p_standbyHold) else $error("standby write acted at once"); // RL12

    property p_holdWrite;
        @(posedge sys_clk) disable iff (sys_rst)
        (hostWrite && execControl == EXEC_PC_ACCESS && deviceNormal && !modeChanged
            && modeSel != MODE_LOAD) |=> pcValue_q == $past(hostData);
    endproperty
    a_holdWrite: assert property (p_holdWrite) else $error("pc write lost"); // RL10

    property p_deferApply;
        @(posedge sys_clk) disable iff (sys_rst)
        (pendingValid_q && deviceNormal && !writeOk && !modeChanged && modeSel != MODE_LOAD)
        |=> pcValue_q == $past(pending_q);
    endproperty
    a_deferApply: assert property (p_deferApply) else $error("standby pc not applied"); // RL12

endmodule : lcs_program_counter
`default_nettype wire

// ===== dv/lcs_host_model.sv
/*
 * Serial-bus controller model standing in for the host processor.
 * Assumes the bench resolves the open-drain data wire with a pull-up.
 */
`timescale 1ns/100ps
`default_nettype none
module lcs_host_model
    import lcs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sdaLine,
    output logic scl,
    output logic sdaOutN
);
    initial
    begin
        scl = 1'b1;
        sdaOutN = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick

    // Data moves only while scl is low, well clear of both scl edges
    task automatic bitx(input logic b, output logic r);
        sdaOutN = b;
        tick(3);
        scl = 1'b1;
        tick(3);
        r = sdaLine;
        scl = 1'b0;
        tick(2);
    endtask : bitx

    // Serves from idle and as a repeated start
    task automatic start();
        sdaOutN = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(3);
        sdaOutN = 1'b0;
        tick(3);
        scl = 1'b0;
        tick(2);
    endtask : start

    task automatic stop();
        sdaOutN = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(3);
        sdaOutN = 1'b1;
        tick(3);
    endtask : stop

    // Ninth bit: released for the target, or the host's own ack
    task automatic xfer(input logic [7:0] tx, input logic last,
                        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--)
            bitx(tx[i], rx[i]);
        bitx(last, ack);
    endtask : xfer
endmodule : lcs_host_model
`default_nettype wire

// ===== dv/tb_top.sv
/*
 * Self-checking bench for the register bank: a table of register round
 * trips, then reset, counter, interrupt and PWM cases by hand.
 * Assumes the host model drives the bus; data wire is pulled up.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import lcs_pkg::*;
();
    typedef struct packed {logic [7:0] off; logic [7:0] wr; logic [7:0] exp;} lcs_row_type;
    localparam logic [15:0] GAP_SLOW = 16'(25_000_000 / (256 * 256));
    localparam logic [15:0] GAP_FAST = 16'(25_000_000 / (558 * 256));
    logic sys_clk, sys_rst, scl, sdaOutN, sdaDriveN_q, intDriveN_q;
    logic deviceNormal, clockDetected, externalClockInUse_q, pwmStepTick_q;
    logic [2:0][1:0] execControl, modeSel;
    logic [2:0] pcAdvance, endPulse;
    logic [1:0] pumpStateReport;
    logic [7:0] blueCurrent_q;
    lcs_config_type config_q;
    logic [2:0][3:0] programCounter;
    wire logic sdaLine;
    int failCount = 0, testsRun = 0, cycles = 0;
    lcs_row_type rows [11] = '{'{8'h07, 8'h00, 8'h00}, '{8'h07, 8'hFF, 8'hFF},
        '{8'h08, 8'h78, 8'h78}, '{8'h08, 8'h0C, 8'h0C}, '{8'h08, 8'h12, 8'h12},
        '{8'h08, 8'h01, 8'h01}, '{8'h08, 8'h03, 8'h03}, '{8'h09, 8'hF5, 8'h05},
        '{8'h0A, 8'h0A, 8'h0A}, '{8'h0B, 8'h03, 8'h03}, '{8'h0E, 8'hAA, 8'h00}};

    assign sdaLine = sdaOutN & sdaDriveN_q;

    lcs_host_model host (.sys_clk(sys_clk), .sdaLine(sdaLine), .scl(scl), .sdaOutN(sdaOutN));

    lcs_register_bank dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .scl(scl), .sdaIn(sdaLine),
        .sdaDriveN_q(sdaDriveN_q), .execControl(execControl), .modeSel(modeSel),
        .pcAdvance(pcAdvance), .endPulse(endPulse), .deviceNormal(deviceNormal),
        .pumpStateReport(pumpStateReport), .clockDetected(clockDetected),
        .blueCurrent_q(blueCurrent_q), .config_q(config_q),
        .externalClockInUse_q(externalClockInUse_q), .pwmStepTick_q(pwmStepTick_q),
        .programCounter(programCounter), .intDriveN_q(intDriveN_q));

    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic closeOut();
        $display("checks %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : closeOut

    // Hang guard, several times the expected run length
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            failCount++;
            closeOut();
        end
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        testsRun++;
        if (seen !== exp)
        begin
            failCount++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic addrByte(input logic rd);
        logic [7:0] rx;
        logic ack;
        host.start();
        host.xfer({DEV_ADDR, rd}, 1'b1, rx, ack);
        check("addrAck", {7'h00, ack}, 8'h00);
    endtask : addrByte

    task automatic regWrite(input logic [7:0] off, input logic [7:0] data);
        logic [7:0] rx;
        logic ack;
        addrByte(1'b0);
        host.xfer(off, 1'b1, rx, ack);
        host.xfer(data, 1'b1, rx, ack);
        check("dataAck", {7'h00, ack}, 8'h00);
        host.stop();
    endtask : regWrite

    // Pointer write, repeated start, one byte ended by a host nack
    task automatic rdCheck(input logic [7:0] off, input logic [7:0] exp);
        logic [7:0] d;
        logic ack;
        addrByte(1'b0);
        host.xfer(off, 1'b1, d, ack);
        addrByte(1'b1);
        host.xfer(8'hFF, 1'b1, d, ack);
        host.stop();
        check("readData", d, exp);
    endtask : rdCheck

    task automatic gapCheck(input logic [15:0] exp);
        logic [15:0] n;
        n = 16'h0000;
        while (pwmStepTick_q !== 1'b1) host.tick(1);
        do
        begin
            host.tick(1);
            n++;
        end while (pwmStepTick_q !== 1'b1);
        check("gapHi", n[15:8], exp[15:8]);
        check("gapLo", n[7:0], exp[7:0]);
    endtask : gapCheck

    initial
    begin
        sys_rst = 1'b1;
        execControl = '1;
        modeSel = {2'b10, 2'b10, 2'b10};
        pcAdvance = 3'b000;
        endPulse = 3'b000;
        deviceNormal = 1'b1;
        pumpStateReport = 2'b01;
        clockDetected = 1'b1;
        host.tick(6);
        sys_rst = 1'b0;
        check("blueCurrent_q", blueCurrent_q, 8'hAF);
        check("config_q", config_q, 8'h00);
        host.tick(2);
        rdCheck(8'h07, 8'hAF);
        for (int o = 9; o <= 11; o++)
            rdCheck(8'(o), 8'h00);
        rdCheck(8'h0C, 8'h18);
        foreach (rows[i])
        begin
            // Bit 7 of every configuration value stays zero
            regWrite(rows[i].off, rows[i].wr);
            rdCheck(rows[i].off, rows[i].exp);
            if (rows[i].off == 8'h08)
            begin
                check("config_q", config_q, rows[i].wr);
                check("extClk", {7'h00, externalClockInUse_q},
                      {7'h00, rows[i].wr[1:0] == 2'b00 || rows[i].wr[1:0] == 2'b10});
            end
        end
        clockDetected = 1'b0;
        pumpStateReport = 2'b11;
        regWrite(8'h08, 8'h02);
        check("extClk", {7'h00, externalClockInUse_q}, 8'h00);
        rdCheck(8'h0C, 8'h30);
        // Red leaves the access state: write and read both refused
        execControl[2] = 2'b00;
        regWrite(8'h09, 8'h0C);
        check("redCounter", {4'h0, programCounter[2]}, 8'h05);
        rdCheck(8'h09, 8'h00);
        execControl[2] = 2'b11;
        deviceNormal = 1'b0;
        regWrite(8'h0A, 8'h06);
        check("greenCounter", {4'h0, programCounter[1]}, 8'h0A);
        rdCheck(8'h0A, 8'h00);
        deviceNormal = 1'b1;
        host.tick(2);
        check("greenCounter", {4'h0, programCounter[1]}, 8'h06);
        modeSel[0] = 2'b11;
        modeSel[2] = 2'b11;
        host.tick(2);
        check("counters", {programCounter[2], programCounter[0]}, 8'h00);
        modeSel[0] = 2'b01;
        execControl[1] = 2'b00;
        pcAdvance = 3'b111;
        host.tick(1);
        pcAdvance = 3'b000;
        host.tick(1);
        check("counters", {programCounter[2], programCounter[0]}, 8'h10);
        check("greenCounter", {4'h0, programCounter[1]}, 8'h06);
        for (int c = 0; c < 3; c++)
        begin
            endPulse = 3'(1 << c);
            host.tick(1);
            endPulse = 3'b000;
            host.tick(1);
            check("intDriveN_q", {7'h00, intDriveN_q}, 8'h00);
            rdCheck(8'h0C, 8'h30 | 8'(1 << c));
            check("intDriveN_q", {7'h00, intDriveN_q}, 8'h01);
        end
        endPulse = 3'b101;
        host.tick(1);
        endPulse = 3'b000;
        rdCheck(8'h0C, 8'h35);
        rdCheck(8'h0C, 8'h30);
        pumpStateReport = 2'b10;
        rdCheck(8'h0C, 8'h20);
        gapCheck(GAP_SLOW);
        regWrite(8'h08, 8'h42);
        gapCheck(GAP_FAST);
        // Second reset in mid-run restores the defaults
        sys_rst = 1'b1;
        host.tick(2);
        sys_rst = 1'b0;
        check("blueCurrent_q", blueCurrent_q, 8'hAF);
        check("counters", {programCounter[1], programCounter[0]}, 8'h00);
        closeOut();
    end
endmodule : tb_top
`default_nettype wire
